/* rtl/kgp_pkg.sv */
// constants for the key-sense general purpose port: register indices, fields, reset values
// assumes a 32-bit classic wishbone bus whose byte address is four times the register index
package kgp_pkg;

    localparam int unsigned PIN_COUNT = 8;
    localparam int unsigned BUF_PIN_COUNT = 4;
    localparam int unsigned BUF_PIN_LOW = 4;
    localparam int unsigned SYNC_STAGES = 2;

    // printed offsets are register indices; the byte address is four times the index
    localparam logic [29:0] IDX_OUTPUT_LATCH = 30'h0000ffaa;
    localparam logic [29:0] IDX_PIN_DIRECTION = 30'h0000ffab;
    localparam logic [29:0] IDX_PIN_LEVEL = 30'h0000ffab;
    localparam logic [29:0] IDX_STANDBY_CONTROL = 30'h0000ffac;

    localparam logic [7:0] RST_OUTPUT_LATCH = 8'h00;
    localparam logic [7:0] RST_PIN_DIRECTION = 8'h00;
    localparam logic [7:0] RST_PULLUP = 8'h00;
    localparam logic RST_BUS_BUFFER_SELECT = 1'b0;

    // standby control register fields
    localparam int unsigned BIT_BUS_BUFFER_SELECT = 0;
    localparam int unsigned BIT_SW_STANDBY_SEEN = 4;
    localparam int unsigned BIT_HW_STANDBY_SEEN = 5;

    localparam logic [31:0] READ_UNMAPPED = 32'h00000000;

endpackage

/* rtl/kgp_sync.sv */
// two flip-flop synchroniser for levels arriving from outside the clk_sys domain
// assumes each bit is an independent level; no bus coherence across bits
`timescale 1ns/1ps

module kgp_sync #(
    parameter int unsigned WIDTH = 8
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    // the first stage feeds only the second stage
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
        end
    end

    assign sync_out = sync_reg;

endmodule

/* rtl/kgp_port.sv */
// eight-pin bidirectional port with key-sense inputs and bus buffer capable upper pins
// assumes a classic wishbone master on clk_sys and external pad logic resolving enables
`timescale 1ns/1ps

// Function
// - eight bidirectional pins, each also feeding a key-sense input.
// - pin functions and selection are the same in every chip mode.
// - upper four pins can act as bus buffers for the serial bus.
// - direction register is write-only, eight bits, at its index, resets zero.
// - output latch is read/write, eight bits, at its index, resets zero.
// - pin level register is read-only at its index, follows the pins.
// - direction and pin level share an index: writes direction, reads levels.
// - direction bit one makes the pin an output, zero an input.
// - direction bits clear on reset and on hardware standby.
// - software standby keeps direction bits, outputs keep driving.
// - output latch holds one data bit for each of eight pins.
// - output latch is writable and readable whatever the direction bits.
// - output latch clears on reset and hardware standby, kept in software standby.
// - pin level reads always return current pin levels, regardless of direction.
// - pull-up on only while latch bit is one and direction bit zero.
// - all pull-ups off on reset and in hardware standby.
// - upper four pins driven as bus buffers while bus buffer select is set.
module kgp_port (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [31:0] wb_adr,
    input wire logic [3:0] wb_sel,
    input wire logic [31:0] wb_dat_w,
    output logic [31:0] wb_dat_r,
    output logic wb_ack,
    input wire logic hw_standby,
    input wire logic sw_standby,
    input wire logic [7:0] pin_in,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe_n,
    output logic [7:0] pullup_en,
    output logic [7:0] key_sense_input,
    output logic [3:0] bus_buffer_en
);

    ////////////////////////////////////////////////////////////////////////////////
    // decode helpers

    function automatic logic idx_hit(input logic [31:0] adr, input logic [29:0] idx);
        idx_hit = (adr[31:2] == idx);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // input synchronisers
    // standby levels come from the pad ring like the pins, so they pass two flops too

    logic [7:0] pin_sync;
    logic [1:0] stby_sync;
    logic hw_stby_s;
    logic sw_stby_s;

    kgp_sync #(
        .WIDTH(kgp_pkg::PIN_COUNT)
    ) u_pin_sync (
        .clk_sys(clk_sys),
        .reset(reset),
        .async_in(pin_in),
        .sync_out(pin_sync)
    );

    kgp_sync #(
        .WIDTH(2)
    ) u_stby_sync (
        .clk_sys(clk_sys),
        .reset(reset),
        .async_in({hw_standby, sw_standby}),
        .sync_out(stby_sync)
    );

    assign hw_stby_s = stby_sync[1];
    assign sw_stby_s = stby_sync[0];

    ////////////////////////////////////////////////////////////////////////////////
    // bus slave: one wait state, ack for exactly one cycle

    logic ack_reg;
    logic [31:0] rdata_reg;
    logic req_fire;
    logic wr_fire;
    logic rd_fire;
    logic wr_latch;
    logic wr_dir;
    logic wr_ctrl;

    // a read is sampled at the taking edge and its data stands in the ack cycle
    assign req_fire = wb_cyc && wb_stb && !ack_reg;
    // writes land at the ack edge, so a master that drops cyc before the answer leaves no trace
    assign wr_fire = wb_cyc && wb_stb && ack_reg && wb_we && wb_sel[0];
    assign rd_fire = req_fire && !wb_we;
    assign wr_latch = wr_fire && idx_hit(wb_adr, kgp_pkg::IDX_OUTPUT_LATCH);
    assign wr_dir = wr_fire && idx_hit(wb_adr, kgp_pkg::IDX_PIN_DIRECTION);
    assign wr_ctrl = wr_fire && idx_hit(wb_adr, kgp_pkg::IDX_STANDBY_CONTROL);

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= req_fire;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // registers and their next values

    logic [7:0] output_latch_reg;
    logic [7:0] output_latch_next;
    logic [7:0] pin_direction_reg;
    logic [7:0] pin_direction_next;
    logic bus_buffer_select_reg;
    logic bus_buffer_select_next;

    // hardware standby clears like reset; software standby has no effect on state
    // a standby clear wins over a write that falls in the same cycle
    always_comb begin
        output_latch_next = output_latch_reg;
        if (hw_stby_s) begin
            output_latch_next = kgp_pkg::RST_OUTPUT_LATCH;
        end else if (wr_latch) begin
            output_latch_next = wb_dat_w[7:0];
        end
    end

    always_comb begin
        pin_direction_next = pin_direction_reg;
        if (hw_stby_s) begin
            pin_direction_next = kgp_pkg::RST_PIN_DIRECTION;
        end else if (wr_dir) begin
            pin_direction_next = wb_dat_w[7:0];
        end
    end

    always_comb begin
        bus_buffer_select_next = bus_buffer_select_reg;
        if (hw_stby_s) begin
            bus_buffer_select_next = kgp_pkg::RST_BUS_BUFFER_SELECT;
        end else if (wr_ctrl) begin
            bus_buffer_select_next = wb_dat_w[kgp_pkg::BIT_BUS_BUFFER_SELECT];
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            output_latch_reg <= kgp_pkg::RST_OUTPUT_LATCH;
        end else begin
            output_latch_reg <= output_latch_next;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            pin_direction_reg <= kgp_pkg::RST_PIN_DIRECTION;
        end else begin
            pin_direction_reg <= pin_direction_next;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            bus_buffer_select_reg <= kgp_pkg::RST_BUS_BUFFER_SELECT;
        end else begin
            bus_buffer_select_reg <= bus_buffer_select_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read mux: the shared index returns pin levels, never the direction bits

    // unmapped indices read zero, so software can probe the map without side effects
    logic [31:0] rdata_next;

    always_comb begin
        rdata_next = kgp_pkg::READ_UNMAPPED;
        if (idx_hit(wb_adr, kgp_pkg::IDX_OUTPUT_LATCH)) begin
            rdata_next = {24'h000000, output_latch_reg};
        end else if (idx_hit(wb_adr, kgp_pkg::IDX_PIN_LEVEL)) begin
            rdata_next = {24'h000000, pin_sync};
        end else if (idx_hit(wb_adr, kgp_pkg::IDX_STANDBY_CONTROL)) begin
            rdata_next[kgp_pkg::BIT_BUS_BUFFER_SELECT] = bus_buffer_select_reg;
            rdata_next[kgp_pkg::BIT_SW_STANDBY_SEEN] = sw_stby_s;
            rdata_next[kgp_pkg::BIT_HW_STANDBY_SEEN] = hw_stby_s;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            rdata_reg <= kgp_pkg::READ_UNMAPPED;
        end else if (rd_fire) begin
            rdata_reg <= rdata_next;
        end else begin
            rdata_reg <= kgp_pkg::READ_UNMAPPED;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // pin drive, pull-ups and key sense; no mode input exists, so no remapping
    // bus buffer mode only raises its enables; the pad ring chooses the buffer over pin_out

    logic [7:0] pin_out_reg;
    logic [7:0] pin_oe_n_reg;
    logic [7:0] pullup_reg;
    logic [7:0] key_sense_reg;
    logic [3:0] bus_buffer_reg;

    // driven from the next values so the pads agree with the registers every cycle
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            pin_out_reg <= kgp_pkg::RST_OUTPUT_LATCH;
            pin_oe_n_reg <= ~kgp_pkg::RST_PIN_DIRECTION;
        end else begin
            pin_out_reg <= output_latch_next;
            pin_oe_n_reg <= ~pin_direction_next;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            pullup_reg <= kgp_pkg::RST_PULLUP;
        end else if (hw_stby_s) begin
            pullup_reg <= kgp_pkg::RST_PULLUP;
        end else begin
            pullup_reg <= output_latch_next & ~pin_direction_next;
        end
    end

    // key sense sees the pin in either direction, like the level register
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            key_sense_reg <= 8'h00;
        end else begin
            key_sense_reg <= pin_sync;
        end
    end

    // one flop per buffer pin keeps each enable next to its own pad
    generate
        for (genvar g = 0; g < kgp_pkg::BUF_PIN_COUNT; g++) begin : g_bus_buffer
            always_ff @(posedge clk_sys or posedge reset) begin
                if (reset) begin
                    bus_buffer_reg[g] <= kgp_pkg::RST_BUS_BUFFER_SELECT;
                end else begin
                    bus_buffer_reg[g] <= bus_buffer_select_next;
                end
            end
        end
    endgenerate

    assign pin_out = pin_out_reg;
    assign pin_oe_n = pin_oe_n_reg;
    assign pullup_en = pullup_reg;
    assign key_sense_input = key_sense_reg;
    assign bus_buffer_en = bus_buffer_reg;
    assign wb_ack = ack_reg;
    assign wb_dat_r = rdata_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // assertions

    // all properties run on clk_sys and are off while reset is high
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    a_dir_write: assert property ((wr_dir && !hw_stby_s) |=>
        (pin_oe_n == ~$past(wb_dat_w[7:0]) && pin_direction_reg == $past(wb_dat_w[7:0])))
        else $error("direction write did not reach the pin enables");

    a_latch_readback: assert property (
        (rd_fire && idx_hit(wb_adr, kgp_pkg::IDX_OUTPUT_LATCH)) |=>
        (wb_ack && wb_dat_r == {24'h000000, $past(output_latch_reg)}))
        else $error("output latch did not read back its value");

    a_latch_write: assert property ((wr_latch && !hw_stby_s) |=>
        (output_latch_reg == $past(wb_dat_w[7:0]) && $stable(pin_direction_reg)))
        else $error("output latch write failed or touched the direction bits");

    a_shared_index: assert property ((wr_dir && !hw_stby_s) |=>
        ($stable(output_latch_reg) && wb_dat_r == kgp_pkg::READ_UNMAPPED))
        else $error("write at the shared index disturbed the latch or read data");

    a_sel_ignored: assert property (
        (wb_cyc && wb_stb && wb_ack && wb_we && !wb_sel[0] && !hw_stby_s) |=>
        ($stable(output_latch_reg) && $stable(pin_direction_reg)))
        else $error("write with the low byte disabled changed a register");

    a_write_late: assert property ((req_fire && wb_we && !hw_stby_s) |=>
        ($stable(output_latch_reg) && $stable(pin_direction_reg)))
        else $error("write took effect before the ack edge");

    a_rdata_idle: assert property (!wb_ack |-> wb_dat_r == kgp_pkg::READ_UNMAPPED)
        else $error("read data not zero outside the ack cycle");

    a_select_write: assert property ((wr_ctrl && !hw_stby_s) |=>
        bus_buffer_en == {4{$past(wb_dat_w[kgp_pkg::BIT_BUS_BUFFER_SELECT])}})
        else $error("bus buffer select write did not reach the enables");

    a_standby_status: assert property (
        (rd_fire && idx_hit(wb_adr, kgp_pkg::IDX_STANDBY_CONTROL)) |=>
        (wb_dat_r[kgp_pkg::BIT_HW_STANDBY_SEEN] == $past(hw_stby_s) &&
        wb_dat_r[kgp_pkg::BIT_SW_STANDBY_SEEN] == $past(sw_stby_s)))
        else $error("standby status bits disagree with the synchronised levels");

    a_level_read: assert property (
        (rd_fire && idx_hit(wb_adr, kgp_pkg::IDX_PIN_LEVEL)) |=>
        wb_dat_r == {24'h000000, $past(pin_sync)})
        else $error("pin level read did not return the synchronised pins");

    a_pin_drive: assert property ((pin_oe_n == ~pin_direction_reg) &&
        (pin_out == output_latch_reg))
        else $error("pin drive disagrees with direction or latch");

    a_pullup_gate: assert property (pullup_en == (output_latch_reg & ~pin_direction_reg))
        else $error("pull-up enable not equal to latch and not direction");

    a_hw_standby_clear: assert property (hw_stby_s |=>
        (pin_direction_reg == 8'h00 && output_latch_reg == 8'h00 && pullup_en == 8'h00))
        else $error("hardware standby did not clear the port");

    a_sw_standby_hold: assert property ((sw_stby_s && !hw_stby_s && !wr_fire) |=>
        ($stable(pin_direction_reg) && $stable(output_latch_reg)))
        else $error("software standby disturbed the port registers");

    a_ack_once: assert property ((wb_cyc && wb_stb && !wb_ack) |=> wb_ack ##1 !wb_ack)
        else $error("bus ack not a single cycle one wait state after request");

    a_bus_buffer: assert property (bus_buffer_en == {4{bus_buffer_select_reg}})
        else $error("bus buffer enables disagree with select bit");

    a_key_sense: assert property (key_sense_input == $past(pin_sync))
        else $error("key sense input does not follow the pins");

    c_dir_write: cover property (wr_dir ##1 pin_oe_n != 8'hff);
    c_level_read: cover property (rd_fire && idx_hit(wb_adr, kgp_pkg::IDX_PIN_LEVEL));
    c_pullup_on: cover property (pullup_en != 8'h00);
    c_hw_standby: cover property ($rose(hw_stby_s) && pin_direction_reg != 8'h00);
    c_sw_standby: cover property (sw_stby_s && pin_direction_reg != 8'h00);

endmodule

/* test/kgp_pad_model.sv */
// pad model: the eight pins with pull-ups and an optional outside driver
// assumes active-low drive enables; the port's own driver wins over the outside one
`timescale 1ns/1ps
module kgp_pad_model (
    input wire logic clk_sys,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe_n,
    input wire logic [7:0] pullup_en,
    input wire logic [7:0] ext_val,
    input wire logic [7:0] ext_en,
    output logic [7:0] pin_in
);
    // starts known so a floating pin toggles from the first edge instead of staying unknown
    logic [7:0] last_reg = 8'h00;
    // floating pins toggle, so a missing pull-up cannot pass by luck
    always @(posedge clk_sys) begin
        last_reg <= pin_in;
    end
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (!pin_oe_n[i]) begin
                pin_in[i] = pin_out[i];
            end else if (ext_en[i]) begin
                pin_in[i] = ext_val[i];
            end else if (pullup_en[i]) begin
                pin_in[i] = 1'b1;
            end else begin
                pin_in[i] = ~last_reg[i];
            end
        end
    end
endmodule

/* test/tb_top.sv */
// bench for the key-sense port: wishbone master, random pin traffic, standby
// assumes the pad model in front of the pins and the register map of kgp_pkg
`timescale 1ns/1ps
module tb_top;
    logic clk_sys = 1'b0, reset = 1'b1, wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
    logic [31:0] wb_adr = 32'h0, wb_dat_w = 32'h0, wb_dat_r, q;
    logic [3:0] wb_sel = 4'h0, bus_buffer_en;
    logic wb_ack, hw_standby = 1'b0, sw_standby = 1'b0;
    logic [7:0] pin_in, pin_out, pin_oe_n, pullup_en, key_sense_input;
    logic [7:0] ext_val = 8'h00, ext_en = 8'h00, lat, dir, m;
    int n_mismatch = 0, checks_done = 0;
    localparam logic [29:0] OL = kgp_pkg::IDX_OUTPUT_LATCH;
    localparam logic [29:0] PD = kgp_pkg::IDX_PIN_DIRECTION;
    localparam logic [29:0] SC = kgp_pkg::IDX_STANDBY_CONTROL;
    always #2.5 clk_sys = ~clk_sys;
    kgp_port i_kgp_port (.clk_sys(clk_sys), .reset(reset), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
        .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w),
        .wb_dat_r(wb_dat_r), .wb_ack(wb_ack), .hw_standby(hw_standby),
        .sw_standby(sw_standby), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .pullup_en(pullup_en), .key_sense_input(key_sense_input),
        .bus_buffer_en(bus_buffer_en));
    kgp_pad_model i_kgp_pad_model (.clk_sys(clk_sys), .pin_out(pin_out),
        .pin_oe_n(pin_oe_n), .pullup_en(pullup_en), .ext_val(ext_val), .ext_en(ext_en),
        .pin_in(pin_in));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic bus(input logic w, input logic [29:0] i, input logic [3:0] s,
            input logic [7:0] d, output logic [31:0] r);
        int n;
        @(posedge clk_sys);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= w;
        wb_adr <= {i, 2'b00};
        wb_sel <= s;
        wb_dat_w <= {24'h0, d};
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (wb_ack !== 1'b1 && n < 20);
        r = wb_dat_r;
        if (n >= 20) n_mismatch++;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask
    task automatic wr(input logic [29:0] i, input logic [7:0] d);
        logic [31:0] r;
        bus(1'b1, i, 4'hf, d, r);
    endtask
    task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic chk_pin(input logic [7:0] g, input logic [7:0] e);
        chk_reg({24'h0, g}, {24'h0, e});
    endtask
    // bits whose level is defined: driven, driven from outside or pulled up
    function automatic logic [7:0] known(input logic [7:0] d, l, ee);
        return d | ee | (l & ~d);
    endfunction
    function automatic logic [7:0] lvl(input logic [7:0] d, l, ev, ee);
        return (d & l) | (~d & ee & ev) | (~d & ~ee & l);
    endfunction
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #100us;
        n_mismatch++;
        tally_and_finish();
    end
    initial begin
        void'($urandom(59802));
        repeat (5) @(posedge clk_sys);
        reset <= 1'b0;
        chk_pin(pin_oe_n, 8'hff);
        chk_pin(pullup_en, 8'h00);
        bus(1'b0, OL, 4'hf, 8'h00, q);
        chk_reg(q, 32'h0);
        $display("test reset_values done");
        for (int k = 0; k < 40; k++) begin
            lat = (k == 0) ? 8'hff : 8'($urandom);
            dir = (k == 0) ? 8'h00 : 8'($urandom);
            ext_val <= 8'($urandom);
            ext_en <= (k == 0) ? 8'h00 : 8'($urandom);
            wr(OL, lat);
            wr(PD, dir);
            repeat (4) @(posedge clk_sys);
            chk_pin(pin_out, lat);
            chk_pin(pin_oe_n, ~dir);
            chk_pin(pullup_en, lat & ~dir);
            bus(1'b0, OL, 4'hf, 8'h00, q);
            chk_reg(q, {24'h0, lat});
            m = known(dir, lat, ext_en);
            bus(1'b0, PD, 4'hf, 8'h00, q);
            chk_pin(q[7:0] & m, lvl(dir, lat, ext_val, ext_en) & m);
            chk_pin(key_sense_input & m, lvl(dir, lat, ext_val, ext_en) & m);
        end
        $display("test random_pins done");
        bus(1'b1, OL, 4'he, 8'h5a, q);
        bus(1'b0, OL, 4'hf, 8'h00, q);
        chk_reg(q, {24'h0, lat});
        bus(1'b0, 30'h0000ff00, 4'hf, 8'h00, q);
        chk_reg(q, kgp_pkg::READ_UNMAPPED);
        $display("test bus_corners done");
        wr(SC, 8'h01);
        repeat (2) @(posedge clk_sys);
        chk_pin({4'h0, bus_buffer_en}, 8'h0f);
        sw_standby <= 1'b1;
        repeat (5) @(posedge clk_sys);
        bus(1'b0, SC, 4'hf, 8'h00, q);
        chk_reg(q, 32'h11);
        chk_pin(pin_oe_n, ~dir);
        chk_pin(pin_out, lat);
        sw_standby <= 1'b0;
        $display("test sw_standby done");
        hw_standby <= 1'b1;
        repeat (5) @(posedge clk_sys);
        chk_pin(pin_oe_n, 8'hff);
        chk_pin(pin_out, 8'h00);
        chk_pin(pullup_en, 8'h00);
        chk_pin({4'h0, bus_buffer_en}, 8'h00);
        bus(1'b0, SC, 4'hf, 8'h00, q);
        chk_reg(q, 32'h20);
        wr(OL, 8'hff);
        hw_standby <= 1'b0;
        repeat (4) @(posedge clk_sys);
        bus(1'b0, OL, 4'hf, 8'h00, q);
        chk_reg(q, 32'h0);
        $display("test hw_standby done");
        wr(OL, 8'h3c);
        wr(PD, 8'hc3);
        reset <= 1'b1;
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        chk_pin(pin_oe_n, 8'hff);
        bus(1'b0, OL, 4'hf, 8'h00, q);
        chk_reg(q, 32'h0);
        $display("test mid_reset done");
        tally_and_finish();
    end
endmodule
